// >>> lrxwb_pkg.sv
// Purpose: constants and carriers for the legacy rx descriptor write-back
// Assumes: 100 MHz mclk, Avalon-MM register slave with byte addresses
// Notes:
// Contract
// - legacy layout is used only while the format select reads 000b
// - after storing data, write back tag, errors, status, checksum, length
// - length counts bytes stored in this buffer, stored CRC included
// - checksum is raw ones-complement sum after IP header, CRC excluded
// - status bits: filter 7, ipv4 6, l4 5, udp 4, vlan 3, eop 1, done 0
// - non-last buffer gets done=1 eop=0 and only its length is valid
// - last buffer gets done=1 eop=1 with every field valid
// - vlan flag set when ethertype matches and vlan mode is enabled
// - no offload means all checksum-done flags clear, incl UDP csum zero
// - unsupported types get no checksum flags; IPv6 never sets ipv4 done
// - hash-only multicast sets filter flag; promisc mcast or bcast clear it
// - forwarded MAC control frame missing exact filters sets filter flag
// - errors: data error 7, ipv4 error 6, l4 error 5, bits 4:0 zero
// - checksum errors only with matching done flag, only on last buffer
// - checksum errors never influence address or type filtering
// - with both offloads disabled, ipv4 and l4 error flags are zero
// - CRC-type errors set data error; bad packets posted only if stored
// - matching vlan packet records tag, else tag field is zero
// - tag holds priority 15:13, canonical bit 12, vlan id 11:0
`default_nettype none
package lrxwb_pkg;

  // register byte offsets
  localparam logic [4:0] LRXWB_CTRL_OFS  = 5'h00;
  localparam logic [4:0] LRXWB_VET_OFS   = 5'h04;
  localparam logic [4:0] LRXWB_STAT_OFS  = 5'h08;
  localparam logic [4:0] LRXWB_WBLO_OFS  = 5'h0C;
  localparam logic [4:0] LRXWB_WBHI_OFS  = 5'h10;

  // control register fields
  localparam int LRXWB_VME_BIT   = 0;
  localparam int LRXWB_MPE_BIT   = 1;
  localparam int LRXWB_BAM_BIT   = 2;
  localparam int LRXWB_PMCF_BIT  = 3;
  localparam int LRXWB_SBP_BIT   = 4;
  localparam int LRXWB_IPOF_BIT  = 5;
  localparam int LRXWB_TUOF_BIT  = 6;
  localparam int LRXWB_FMT_LSB   = 8;
  localparam logic [10:0] LRXWB_CTRL_RST = 11'h000;
  localparam logic [2:0]  LRXWB_FMT_LEGACY = 3'h0;
  localparam logic [15:0] LRXWB_VET_RST = 16'h8100;

  // status byte bits
  localparam int LRXWB_ST_DD   = 0;
  localparam int LRXWB_ST_EOP  = 1;
  localparam int LRXWB_ST_VP   = 3;
  localparam int LRXWB_ST_UDP  = 4;
  localparam int LRXWB_ST_L4   = 5;
  localparam int LRXWB_ST_IPV4 = 6;
  localparam int LRXWB_ST_PIF  = 7;
  // error byte bits
  localparam int LRXWB_ER_L4   = 5;
  localparam int LRXWB_ER_IPV4 = 6;
  localparam int LRXWB_ER_RXE  = 7;

  // one received byte with its placement flags
  typedef struct packed {
    logic [7:0] data;
    logic       stored;   // byte was placed in the host buffer
    logic       past_ip;  // byte lies after the IP header
    logic       is_crc;   // byte belongs to the CRC
  } lrxwb_byte_t;

  // per-packet results from the filter, parser and checksum blocks
  typedef struct packed {
    logic [15:0] ethertype;
    logic [15:0] vlan_tag;
    logic        ipv4;
    logic        ipv6;
    logic        tcp;
    logic        udp;
    logic        udp_csum_zero;
    logic        ipv4_csum_bad;
    logic        l4_csum_bad;
    logic        crc_error;
    logic        da_multicast;
    logic        da_broadcast;
    logic        exact_match;
    logic        hash_match;
    logic        mac_ctrl;
  } lrxwb_pkt_t;

  // second descriptor word as written back
  typedef struct packed {
    logic [15:0] vlan_tag;
    logic [7:0]  errors;
    logic [7:0]  status;
    logic [15:0] frag_csum;
    logic [15:0] length;
  } lrxwb_wb_t;

  // end-around carry add for the fragment checksum
  function automatic logic [15:0] lrxwb_csum_add(input logic [15:0] a,
                                                 input logic [15:0] b);
    logic [16:0] s;
    s = {1'b0, a} + {1'b0, b};
    return s[15:0] + {15'h0000, s[16]};
  endfunction

endpackage
`default_nettype wire

// >>> lrxwb_core.sv
// Purpose: legacy receive descriptor write-back builder with register slave
// Assumes: byte stream and per-packet results synchronous to mclk
// Notes: one write-back per buffer close in legacy format except a dropped bad packet's last buffer, pulsed one cycle after buf_done
`timescale 1ns/1ps
`default_nettype none
module lrxwb_core (
  input  wire logic                 mclk,
  input  wire logic                 reset,
  // avalon-mm register slave
  input  wire logic [4:0]           avs_address,
  input  wire logic                 avs_read,
  input  wire logic                 avs_write,
  input  wire logic [31:0]          avs_writedata,
  input  wire logic [3:0]           avs_byteenable,
  output logic [31:0]               avs_readdata,
  output logic                      avs_waitrequest,
  // received byte stream
  input  wire logic                 rx_valid,
  input  wire lrxwb_pkg::lrxwb_byte_t rx_byte,
  // buffer close and packet results
  input  wire logic                 buf_done,
  input  wire logic                 buf_last,
  input  wire lrxwb_pkg::lrxwb_pkt_t pkt_info,
  // descriptor write-back
  output logic                      wb_valid,
  output lrxwb_pkg::lrxwb_wb_t      wb_word,
  output logic                      bad_pkt_drop
);
  import lrxwb_pkg::*;

  logic [10:0] ctrl;
  logic [15:0] vlan_ethertype_value;
  logic        bus_ack;
  logic [15:0] wb_count;
  logic [15:0] drop_count;
  logic [15:0] byte_count;
  logic [15:0] csum_acc;
  logic [7:0]  csum_hi;
  logic        csum_odd;
  logic [15:0] next_byte_count;
  logic [15:0] next_csum_acc;
  logic [7:0]  next_csum_hi;
  logic        next_csum_odd;
  logic [15:0] final_csum;
  logic        legacy;
  logic        vlan_hit;
  logic        drop_now;
  logic        ipv4_csum_done;
  logic        l4_csum_done;
  logic        udp_csum_done;
  logic        imperfect_filter_hit;
  logic [7:0]  next_status;
  logic [7:0]  next_errors;
  logic [31:0] next_rdata;
  lrxwb_wb_t   next_wb;

  // legacy layout only with format select 000b
  assign legacy = ctrl[LRXWB_FMT_LSB +: 3] == LRXWB_FMT_LEGACY;

  // one wait cycle per access, data stands when waitrequest drops
  assign avs_waitrequest = (avs_read | avs_write) & ~bus_ack;

  always_ff @(posedge mclk) begin
    if (reset) begin
      bus_ack <= 1'b0;
    end else begin
      bus_ack <= (avs_read | avs_write) & ~bus_ack;
    end
  end

  // control and ethertype registers, written on the accepting edge
  always_ff @(posedge mclk) begin
    if (reset) begin
      ctrl <= LRXWB_CTRL_RST;
      vlan_ethertype_value  <= LRXWB_VET_RST;
    end else if (avs_write & bus_ack) begin
      if (avs_address == LRXWB_CTRL_OFS) begin
        if (avs_byteenable[0]) begin
          ctrl[7:0] <= avs_writedata[7:0];
        end
        if (avs_byteenable[1]) begin
          ctrl[10:8] <= avs_writedata[10:8];
        end
      end else if (avs_address == LRXWB_VET_OFS) begin
        if (avs_byteenable[0]) begin
          vlan_ethertype_value[7:0] <= avs_writedata[7:0];
        end
        if (avs_byteenable[1]) begin
          vlan_ethertype_value[15:8] <= avs_writedata[15:8];
        end
      end
    end
  end

  // read mux; unmapped offsets read zero
  always_comb begin
    unique case (avs_address)
      LRXWB_CTRL_OFS: next_rdata = {21'h000000, ctrl};
      LRXWB_VET_OFS:  next_rdata = {16'h0000, vlan_ethertype_value};
      LRXWB_STAT_OFS: next_rdata = {drop_count, wb_count};
      LRXWB_WBLO_OFS: next_rdata = wb_word[31:0];
      LRXWB_WBHI_OFS: next_rdata = wb_word[63:32];
      default:        next_rdata = 32'h00000000;
    endcase
  end

  always_ff @(posedge mclk) begin
    if (reset) begin
      avs_readdata <= 32'h00000000;
    end else if (avs_read & ~bus_ack) begin
      avs_readdata <= next_rdata;
    end
  end

  // per-buffer length and running fragment sum, including this cycle's byte
  always_comb begin
    next_byte_count = byte_count;
    next_csum_acc   = csum_acc;
    next_csum_hi    = csum_hi;
    next_csum_odd   = csum_odd;
    if (rx_valid & rx_byte.stored) begin
      next_byte_count = byte_count + 16'h0001;
    end
    if (rx_valid & rx_byte.past_ip & ~rx_byte.is_crc) begin
      // bytes pair big-end first into 16-bit words
      if (csum_odd) begin
        next_csum_acc = lrxwb_csum_add(csum_acc, {csum_hi, rx_byte.data});
        next_csum_odd = 1'b0;
      end else begin
        next_csum_hi  = rx_byte.data;
        next_csum_odd = 1'b1;
      end
    end
  end

  // an odd trailing byte is padded with zero, no final inversion
  assign final_csum = next_csum_odd ?
    lrxwb_csum_add(next_csum_acc, {next_csum_hi, 8'h00}) :
    next_csum_acc;

  // length restarts per buffer, checksum runs over the whole packet
  always_ff @(posedge mclk) begin
    if (reset) begin
      byte_count <= 16'h0000;
    end else if (buf_done) begin
      byte_count <= 16'h0000;
    end else begin
      byte_count <= next_byte_count;
    end
  end

  always_ff @(posedge mclk) begin
    if (reset) begin
      csum_acc <= 16'h0000;
      csum_hi  <= 8'h00;
      csum_odd <= 1'b0;
    end else if (buf_done & buf_last) begin
      csum_acc <= 16'h0000;
      csum_hi  <= 8'h00;
      csum_odd <= 1'b0;
    end else begin
      csum_acc <= next_csum_acc;
      csum_hi  <= next_csum_hi;
      csum_odd <= next_csum_odd;
    end
  end

  // vlan match needs both the ethertype and vlan mode
  assign vlan_hit = ctrl[LRXWB_VME_BIT] &
                    (pkt_info.ethertype == vlan_ethertype_value);

  // checksum-done flags; IPv6 never reports ipv4 done
  assign ipv4_csum_done  = ctrl[LRXWB_IPOF_BIT] & pkt_info.ipv4 & ~pkt_info.ipv6;
  assign l4_csum_done  = ctrl[LRXWB_TUOF_BIT] & pkt_info.tcp &
                 (pkt_info.ipv4 | pkt_info.ipv6);
  // UDP over IPv4 with a zero checksum is not offloaded
  assign udp_csum_done = ctrl[LRXWB_TUOF_BIT] & pkt_info.udp & ~pkt_info.tcp &
                 (pkt_info.ipv6 | (pkt_info.ipv4 & ~pkt_info.udp_csum_zero));

  // imperfect filter uses address and control-frame results only, never checksum status
  assign imperfect_filter_hit = (pkt_info.da_multicast & ~pkt_info.da_broadcast &
                pkt_info.hash_match & ~pkt_info.exact_match &
                ~ctrl[LRXWB_MPE_BIT]) |
               (pkt_info.da_broadcast & ~ctrl[LRXWB_BAM_BIT] &
                ~pkt_info.exact_match) |
               (pkt_info.mac_ctrl & ~ctrl[LRXWB_PMCF_BIT] &
                ~pkt_info.exact_match);

  // a bad frame's last buffer is only posted when store-bad-packets is on
  assign drop_now = buf_done & buf_last & pkt_info.crc_error &
                    ~ctrl[LRXWB_SBP_BIT];

  // status and error bytes; non-last buffers carry done only
  always_comb begin
    next_status = 8'h00;
    next_errors = 8'h00;
    next_status[LRXWB_ST_DD] = 1'b1;
    if (buf_last) begin
      next_status[LRXWB_ST_EOP]  = 1'b1;
      next_status[LRXWB_ST_PIF]  = imperfect_filter_hit;
      next_status[LRXWB_ST_IPV4] = ipv4_csum_done;
      next_status[LRXWB_ST_L4]   = l4_csum_done;
      next_status[LRXWB_ST_UDP]  = udp_csum_done;
      next_status[LRXWB_ST_VP]   = vlan_hit;
      next_errors[LRXWB_ER_RXE]  = pkt_info.crc_error;
      // errors only alongside their done flag
      next_errors[LRXWB_ER_IPV4] = ipv4_csum_done & pkt_info.ipv4_csum_bad;
      next_errors[LRXWB_ER_L4]   = (l4_csum_done | udp_csum_done) & pkt_info.l4_csum_bad;
    end
  end

  // second word assembly in its fixed field order
  always_comb begin
    next_wb.vlan_tag  = 16'h0000;
    next_wb.errors    = next_errors;
    next_wb.status    = next_status;
    next_wb.frag_csum = buf_last ? final_csum : 16'h0000;
    next_wb.length    = next_byte_count;
    if (buf_last & vlan_hit) begin
      // tag kept in network order: priority, canonical bit, id
      next_wb.vlan_tag = pkt_info.vlan_tag;
    end
  end

  // write-back pulse; a dropped bad packet's last buffer gets none
  always_ff @(posedge mclk) begin
    if (reset) begin
      wb_valid     <= 1'b0;
      bad_pkt_drop <= 1'b0;
    end else begin
      wb_valid     <= buf_done & legacy & ~drop_now;
      bad_pkt_drop <= drop_now & legacy;
    end
  end

  always_ff @(posedge mclk) begin
    if (reset) begin
      wb_word <= '0;
    end else if (buf_done & legacy & ~drop_now) begin
      wb_word <= next_wb;
    end
  end

  // software-visible event counters
  always_ff @(posedge mclk) begin
    if (reset) begin
      wb_count   <= 16'h0000;
      drop_count <= 16'h0000;
    end else begin
      if (buf_done & legacy & ~drop_now) begin
        wb_count <= wb_count + 16'h0001;
      end
      if (drop_now & legacy) begin
        drop_count <= drop_count + 16'h0001;
      end
    end
  end

  // assertions
  sequence s_buf_close;
    buf_done && legacy && !drop_now;
  endsequence

  sequence s_bus_req;
    (avs_read || avs_write) && avs_waitrequest;
  endsequence

  a_close_writes: assert property (@(posedge mclk) disable iff (reset)
    s_buf_close |=> wb_valid && wb_word.status[LRXWB_ST_DD])
    else $error("buffer close gave no write-back");

  a_legacy_gate: assert property (@(posedge mclk) disable iff (reset)
    wb_valid |-> $past(ctrl[LRXWB_FMT_LSB +: 3]) == 3'h0)
    else $error("write-back outside legacy format");

  a_no_rsv_combo: assert property (@(posedge mclk) disable iff (reset)
    wb_valid |-> !(wb_word.status[1] && !wb_word.status[0]))
    else $error("eop written without done");

  a_nonlast_clean: assert property (@(posedge mclk) disable iff (reset)
    (buf_done && !buf_last && legacy) |=>
      wb_word.status == 8'h01 && wb_word.errors == 8'h00 &&
      wb_word.vlan_tag == 16'h0000)
    else $error("non-last descriptor carries extra fields");

  a_last_eop: assert property (@(posedge mclk) disable iff (reset)
    s_buf_close ##0 buf_last |=> wb_word.status[1:0] == 2'b11)
    else $error("last buffer missing done or eop");

  a_vlan_tie: assert property (@(posedge mclk) disable iff (reset)
    wb_valid |-> (wb_word.status[3] ||
                  wb_word.vlan_tag == 16'h0000))
    else $error("tag present without vlan flag");

  a_vlan_flag: assert property (@(posedge mclk) disable iff (reset)
    s_buf_close ##0 buf_last |=>
      wb_word.status[3] == $past(ctrl[0] && pkt_info.ethertype == vlan_ethertype_value))
    else $error("vlan flag does not follow match and mode");

  a_err_rsvd: assert property (@(posedge mclk) disable iff (reset)
    wb_valid |-> wb_word.errors[4:0] == 5'h00 &&
                 wb_word.status[2] == 1'b0)
    else $error("reserved bits written non-zero");

  a_offload_off: assert property (@(posedge mclk) disable iff (reset)
    wb_valid && !$past(ctrl[5]) && !$past(ctrl[6]) |->
      wb_word.errors[6:5] == 2'b00 &&
      wb_word.status[6:4] == 3'b000)
    else $error("checksum results with offload disabled");

  a_err_needs_done: assert property (@(posedge mclk) disable iff (reset)
    wb_valid |-> (!wb_word.errors[6] || wb_word.status[6]) &&
      (!wb_word.errors[5] || (wb_word.status[5] || wb_word.status[4])))
    else $error("checksum error without done flag");

  a_ipv6_noipcs: assert property (@(posedge mclk) disable iff (reset)
    s_buf_close ##0 pkt_info.ipv6 |=> !wb_word.status[6])
    else $error("ipv4 done set on IPv6 packet");

  a_bad_dropped: assert property (@(posedge mclk) disable iff (reset)
    drop_now && legacy |=> !wb_valid && bad_pkt_drop)
    else $error("bad packet posted without store-bad-packets");

  a_bus_answer: assert property (@(posedge mclk) disable iff (reset)
    s_bus_req |=> !avs_waitrequest)
    else $error("bus access not answered in one cycle");

  // last-buffer close that is actually posted
  sequence s_last_close;
    s_buf_close ##0 buf_last;
  endsequence

  a_nonlast_csum: assert property (
    @(posedge mclk) disable iff (reset)
    (buf_done && !buf_last && legacy) |=> wb_word.frag_csum == 16'h0000)
    else $error("non-last descriptor carries a checksum");

  a_errs_last_only: assert property (
    @(posedge mclk) disable iff (reset)
    wb_valid && !wb_word.status[LRXWB_ST_EOP] |-> wb_word.errors == 8'h00)
    else $error("error bits on a non-last descriptor");

  a_udp_excl: assert property (
    @(posedge mclk) disable iff (reset)
    wb_valid |-> !(wb_word.status[LRXWB_ST_L4] &&
                   wb_word.status[LRXWB_ST_UDP]))
    else $error("both l4 and udp checksum done set");

  a_ipv4_csum_done_needs_v4: assert property (
    @(posedge mclk) disable iff (reset)
    s_last_close ##0 !pkt_info.ipv4 |=> !wb_word.status[LRXWB_ST_IPV4])
    else $error("ipv4 done set on a packet without ipv4");

  a_pif_hash: assert property (
    @(posedge mclk) disable iff (reset)
    s_last_close ##0 (pkt_info.da_multicast && !pkt_info.da_broadcast &&
      pkt_info.hash_match && !pkt_info.exact_match &&
      !ctrl[LRXWB_MPE_BIT]) |=> wb_word.status[LRXWB_ST_PIF])
    else $error("hash-only multicast without filter flag");

  a_pif_mpe_clear: assert property (
    @(posedge mclk) disable iff (reset)
    s_last_close ##0 (pkt_info.da_multicast && !pkt_info.da_broadcast &&
      !pkt_info.mac_ctrl && ctrl[LRXWB_MPE_BIT]) |=>
      !wb_word.status[LRXWB_ST_PIF])
    else $error("filter flag set under promiscuous multicast");

  a_pif_ctrl: assert property (
    @(posedge mclk) disable iff (reset)
    s_last_close ##0 (pkt_info.mac_ctrl && !pkt_info.exact_match &&
      !ctrl[LRXWB_PMCF_BIT]) |=> wb_word.status[LRXWB_ST_PIF])
    else $error("forwarded control frame without filter flag");

  a_wb_or_drop: assert property (
    @(posedge mclk) disable iff (reset)
    !(wb_valid && bad_pkt_drop))
    else $error("packet both posted and dropped");

  // the word seen by software moves only with a write-back pulse
  a_wb_hold: assert property (
    @(posedge mclk) disable iff (reset)
    !wb_valid |-> $stable(wb_word))
    else $error("write-back word changed without a pulse");

endmodule
`default_nettype wire

// >>> lrxwb_host_model.sv
// Purpose: host driver stand-in consuming written-back descriptors
// Assumes: one descriptor handed back per wb_valid pulse
// Notes: sums buffer lengths per packet, flags the reserved done/eop code
`timescale 1ns/1ps
`default_nettype none
module lrxwb_host_model (
  input  wire logic              mclk,
  input  wire logic              reset,
  input  wire logic              wb_valid,
  input  wire lrxwb_pkg::lrxwb_wb_t wb_word,
  output logic [15:0]            pkt_len,
  output logic                   bad_combo,
  output logic                   inspect
);
  import lrxwb_pkg::*;
  logic [15:0] run_len;

  // lengths only add up once the end-of-packet descriptor arrives
  always_ff @(posedge mclk) begin
    if (reset) begin
      run_len   <= 16'h0000;
      pkt_len   <= 16'h0000;
      bad_combo <= 1'b0;
      inspect   <= 1'b0;
    end else if (wb_valid) begin
      if (wb_word.status[LRXWB_ST_EOP]) begin
        pkt_len <= run_len + wb_word.length;
        run_len <= 16'h0000;
        inspect <= wb_word.status[LRXWB_ST_PIF];
      end else begin
        run_len <= run_len + wb_word.length;
      end
      // done clear with eop set must never come back
      if (!wb_word.status[LRXWB_ST_DD] && wb_word.status[LRXWB_ST_EOP]) begin
        bad_combo <= 1'b1;
      end
    end
  end
endmodule
`default_nettype wire

// >>> legacy_rx_descriptor_writeback_bench.sv
// Purpose: self-checking bench for the legacy rx write-back builder
// Assumes: write-back one cycle after buf_done; bus waits on waitrequest
// Notes: a watchdog cuts hangs short; stimulus is fixed, not random
`timescale 1ns/1ps
`default_nettype none
module legacy_rx_descriptor_writeback_bench;
  import lrxwb_pkg::*;
  localparam logic [12:0] F_IP4 = 13'h1000, F_IP6 = 13'h0800;
  localparam logic [12:0] F_TCP = 13'h0400, F_UDP = 13'h0200;
  localparam logic [12:0] F_UZ = 13'h0100, F_IPB = 13'h0080;
  localparam logic [12:0] F_L4B = 13'h0040, F_CRC = 13'h0020;
  localparam logic [12:0] F_MC = 13'h0010, F_BC = 13'h0008;
  localparam logic [12:0] F_EX = 13'h0004, F_HASH = 13'h0002;
  localparam logic [12:0] F_MAC = 13'h0001;
  logic        mclk, reset, avs_read, avs_write, avs_waitrequest;
  logic        rx_valid, buf_done, buf_last, wb_valid, bad_pkt_drop;
  logic        bad_combo, inspect;
  logic [4:0]  avs_address;
  logic [31:0] avs_writedata, avs_readdata;
  logic [3:0]  avs_byteenable;
  logic [15:0] pkt_len;
  logic [63:0] last_wb;
  lrxwb_byte_t rx_byte;
  lrxwb_pkt_t  pkt_info;
  lrxwb_wb_t   wb_word;
  int          n_mismatch, n_compared, n_wb, n_drop;

  lrxwb_core dut (.mclk(mclk), .reset(reset), .avs_address(avs_address),
    .avs_read(avs_read), .avs_write(avs_write),
    .avs_writedata(avs_writedata), .avs_byteenable(avs_byteenable),
    .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest),
    .rx_valid(rx_valid), .rx_byte(rx_byte), .buf_done(buf_done),
    .buf_last(buf_last), .pkt_info(pkt_info), .wb_valid(wb_valid),
    .wb_word(wb_word), .bad_pkt_drop(bad_pkt_drop));
  lrxwb_host_model u_host (.mclk(mclk), .reset(reset), .wb_valid(wb_valid),
    .wb_word(wb_word), .pkt_len(pkt_len), .bad_combo(bad_combo),
    .inspect(inspect));

  // free-running 100 MHz clock
  initial mclk = 1'b0;
  always #5 mclk = ~mclk;

  task automatic end_of_test();
    if (n_mismatch == 0 && n_compared > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask

  task automatic chk(input logic [63:0] seen, input logic [63:0] exp);
    n_compared++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("Error at %0t: saw %h expected %h", $time, seen, exp);
    end
  endtask

  // request stands until waitrequest is seen low at a rising edge;
  // only the watchdog ends a wait that never finishes
  task automatic bus(input logic wr, input logic [4:0] a,
                     input logic [31:0] d, input logic [3:0] be,
                     output logic [31:0] q);
    @(posedge mclk);
    avs_address    <= a;
    avs_writedata  <= d;
    avs_byteenable <= be;
    avs_write      <= wr;
    avs_read       <= !wr;
    do begin
      @(posedge mclk);
    end while (avs_waitrequest !== 1'b0);
    q = avs_readdata;
    avs_read  <= 1'b0;
    avs_write <= 1'b0;
  endtask

  task automatic wr(input logic [4:0] a, input logic [31:0] d,
                    input logic [3:0] be);
    logic [31:0] q;
    bus(1'b1, a, d, be, q);
  endtask

  task automatic rdc(input logic [4:0] a, input logic [31:0] e);
    logic [31:0] q;
    bus(1'b0, a, 32'h0000_0000, 4'hF, q);
    chk(q, e);
  endtask

  // one byte per cycle, flags are {stored, past_ip, is_crc}
  task automatic put(input logic [7:0] d, input logic [2:0] fl,
                     input logic dn, input logic ls);
    @(posedge mclk);
    rx_valid <= 1'b1;
    rx_byte  <= {d, fl};
    buf_done <= dn;
    buf_last <= ls;
  endtask

  task automatic fin(input logic ev, input logic ed, input logic [63:0] exp,
                     input logic [7:0] msk);
    @(posedge mclk);
    rx_valid <= 1'b0;
    buf_done <= 1'b0;
    buf_last <= 1'b0;
    #1;
    chk(wb_valid, ev);
    chk(bad_pkt_drop, ed);
    if (ev) begin
      chk(wb_word & {24'hFFFFFF, msk, 32'hFFFFFFFF}, exp);
      last_wb = exp;
      n_wb++;
    end
    if (ed) n_drop++;
  endtask

  // two-byte single-buffer packet, sum 0x1234 and length 2
  task automatic one(input logic [12:0] f, input logic [15:0] et,
                     input logic [7:0] st, input logic [7:0] er,
                     input logic [15:0] tg, input logic ev, input logic ed,
                     input logic [7:0] msk);
    put(8'h12, 3'h6, 1'b0, 1'b0);
    pkt_info <= {et, 16'hB123, f};
    put(8'h34, 3'h6, 1'b1, 1'b1);
    fin(ev, ed, {tg, er, st & msk, 16'h1234, 16'h0002}, msk);
  endtask

  // hang guard, far beyond the length of the sequence
  initial begin
    repeat (20000) @(posedge mclk);
    n_mismatch++;
    end_of_test();
  end

  initial begin
    {reset, avs_read, avs_write, rx_valid, buf_done, buf_last} = 6'h20;
    {avs_address, avs_writedata, avs_byteenable} = 41'h0;
    rx_byte = '0;
    pkt_info = '0;
    {n_mismatch, n_compared, n_wb, n_drop} = 128'h0;
    last_wb = 64'h0;
    repeat (5) @(posedge mclk);
    reset <= 1'b0;
    rdc(LRXWB_CTRL_OFS, 32'h0000_0000);
    rdc(LRXWB_VET_OFS, 32'h0000_8100);
    rdc(5'h14, 32'h0000_0000);
    wr(LRXWB_VET_OFS, 32'h0000_1234, 4'h1);
    rdc(LRXWB_VET_OFS, 32'h0000_8134);
    wr(LRXWB_VET_OFS, 32'h0000_8100, 4'hF);
    wr(LRXWB_CTRL_OFS, 32'h0000_0061, 4'hF);
    // two-buffer packet: odd tail byte, stored CRC counted in length
    pkt_info <= {16'h8100, 16'hB123, F_IP4 | F_UDP | F_L4B};
    put(8'h77, 3'h4, 1'b0, 1'b0);
    put(8'h12, 3'h6, 1'b0, 1'b0);
    put(8'h34, 3'h6, 1'b1, 1'b0);
    fin(1'b1, 1'b0, 64'h0000_0001_0000_0003, 8'hFF);
    put(8'hFF, 3'h6, 1'b0, 1'b0);
    put(8'hFF, 3'h6, 1'b0, 1'b0);
    put(8'h01, 3'h6, 1'b0, 1'b0);
    put(8'hAB, 3'h7, 1'b0, 1'b0);
    put(8'hCD, 3'h7, 1'b1, 1'b1);
    fin(1'b1, 1'b0, 64'hB123_205B_1334_0005, 8'hFF);
    @(posedge mclk);
    #1 chk(pkt_len, 16'h0008);
    one(F_IP4 | F_TCP | F_IPB, 16'h8100, 8'h6B, 8'h40, 16'hB123,
        1'b1, 1'b0, 8'hFF);
    one(F_IP4 | F_UDP | F_UZ, 16'h0800, 8'h43, 8'h00, 16'h0000,
        1'b1, 1'b0, 8'hFF);
    one(13'h0000, 16'h0800, 8'h03, 8'h00, 16'h0000,
        1'b1, 1'b0, 8'hFF);
    one(F_IP6 | F_TCP, 16'h86DD, 8'h03, 8'h00, 16'h0000,
        1'b1, 1'b0, 8'hDF);
    one(F_MC | F_HASH | F_IPB, 16'h0800, 8'h83, 8'h00, 16'h0000,
        1'b1, 1'b0, 8'hFF);
    @(posedge mclk);
    #1 chk(inspect, 1'b1);
    one(F_MAC, 16'h8808, 8'h83, 8'h00, 16'h0000,
        1'b1, 1'b0, 8'hFF);
    one(F_MAC | F_EX, 16'h8808, 8'h03, 8'h00, 16'h0000,
        1'b1, 1'b0, 8'hFF);
    one(F_BC, 16'h0800, 8'h83, 8'h00, 16'h0000, 1'b1, 1'b0, 8'hFF);
    wr(LRXWB_CTRL_OFS, 32'h0000_0067, 4'hF);
    one(F_MC | F_HASH, 16'h0800, 8'h03, 8'h00, 16'h0000,
        1'b1, 1'b0, 8'hFF);
    one(F_BC, 16'h0800, 8'h03, 8'h00, 16'h0000, 1'b1, 1'b0, 8'hFF);
    // offloads off: no done flags and no checksum errors
    wr(LRXWB_CTRL_OFS, 32'h0000_0001, 4'hF);
    one(F_IP4 | F_TCP | F_IPB | F_L4B, 16'h8100, 8'h0B, 8'h00, 16'hB123,
        1'b1, 1'b0, 8'hFF);
    wr(LRXWB_CTRL_OFS, 32'h0000_0061, 4'hF);
    one(F_CRC, 16'h0800, 8'h00, 8'h00, 16'h0000,
        1'b0, 1'b1, 8'hFF);
    wr(LRXWB_CTRL_OFS, 32'h0000_0171, 4'hF);
    one(F_IP4, 16'h0800, 8'h00, 8'h00, 16'h0000, 1'b0, 1'b0, 8'hFF);
    wr(LRXWB_CTRL_OFS, 32'h0000_0071, 4'hF);
    one(F_CRC | F_IP4 | F_TCP, 16'h0800, 8'h63, 8'h80, 16'h0000,
        1'b1, 1'b0, 8'hFF);
    wr(LRXWB_STAT_OFS, 32'hFFFF_FFFF, 4'hF);
    rdc(LRXWB_STAT_OFS, {n_drop[15:0], n_wb[15:0]});
    rdc(LRXWB_WBLO_OFS, last_wb[31:0]);
    rdc(LRXWB_WBHI_OFS, last_wb[63:32]);
    chk(bad_combo, 1'b0);
    end_of_test();
  end
endmodule
`default_nettype wire
